// ---- tpb_pkg.sv ----
package tpb_pkg;

    // ****************************************
    // Register map, byte wide
    // ****************************************
    localparam logic [3:0]  ADDR_CTRL      = 4'h0;
    localparam logic [3:0]  ADDR_CNT_HI    = 4'h1;
    localparam logic [3:0]  ADDR_CNT_LO    = 4'h2;
    localparam logic [3:0]  ADDR_MOD_HI    = 4'h3;
    localparam logic [3:0]  ADDR_MOD_LO    = 4'h4;
    localparam logic [3:0]  ADDR_CHV_BASE  = 4'h5;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int          PS_LSB         = 0;
    localparam int          PS_W           = 3;
    localparam int          SRC_LSB        = 3;
    localparam int          SRC_W          = 2;
    localparam int          CENTER_BIT     = 5;
    localparam int          CTRL_W         = 6;
    localparam logic [2:0]  PS_DIV2        = 3'h1;
    localparam logic [1:0]  SRC_OFF        = 2'h0;

    // ****************************************
    // Reset values and sizes
    // ****************************************
    localparam logic [5:0]  CTRL_RESET     = 6'h00;
    localparam logic [15:0] MOD_RESET      = 16'hFFFF;
    localparam logic [15:0] CHV_RESET      = 16'h0000;
    localparam logic [15:0] CNT_RESET      = 16'h0000;
    localparam logic [7:0]  LATCH_RESET    = 8'h00;
    localparam logic [7:0]  RD_IDLE        = 8'h00;
    localparam int          PRESCALE_DIV_W = 7;
    localparam int          CHANNELS_DEF   = 2;

endpackage

// ---- tpb_prescaler.sv ----
module tpb_prescaler #(
    parameter int DIV_W = tpb_pkg::PRESCALE_DIV_W
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic [DIV_W-1:0] sel_mask;

    function automatic logic [DIV_W-1:0] ratio_mask(input logic [2:0] s);
        ratio_mask = DIV_W'((1 << s) - 1);
    endfunction

    // Select 001 gives divide by two
    assign sel_mask = ratio_mask(sel);
    assign tick     = run && ((div_reg & sel_mask) == sel_mask);
    // Divider only holds when stopped, never clears
    assign div_next = run ? div_reg + 1'b1 : div_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_div2_alternates: assert property (
        (run && sel == tpb_pkg::PS_DIV2) [*2] |-> tick != $past(tick)
    ) else $error("Divide by two does not alternate");

    a_div_kept_stop: assert property (
        !run |=> $stable(div_reg)
    ) else $error("Prescaler state lost while stopped");

endmodule

// ---- tpb_timer_pwm.sv ----
// Functional notes
// - Center mode counts up to modulo, back down to zero; period is twice modulo.
// - Center mode: channel equal to modulo keeps the output inactive.
// - Center mode: channel equal to modulo minus one keeps output inactive.
// - Negative channel values force a permanently inactive output.
// - Prescale select 001 means divide by two.
// - Zero to non-zero while counting down: output goes active at count zero.
// - Non-zero to zero while counting up: output active until period end.
// - Zero, non-zero, zero across down-counts: active one and a half periods.
// - Edge mode: zero to non-zero costs one extra 0% period.
// - Clock source select 00 stops the counter; non-zero restarts it.
// - Any write to either counter byte clears the counter.
// - Prescaler divider is never cleared by stop, prescale change or clear.
// - Center up-count turns to down-count on the same edge that reaches modulo.
// - Counter clear keeps direction; cleared at modulo it wraps downward.
module tpb_timer_pwm #(
    parameter int CHANNELS = tpb_pkg::CHANNELS_DEF
) (
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic [3:0]          addr,
    input  wire logic [7:0]          wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [7:0]          rd_data,
    output logic      [CHANNELS-1:0] pwm_out
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ****************************************
    // Declarations
    // ****************************************
    logic [tpb_pkg::CTRL_W-1:0] ctrl_reg;
    logic [15:0]                mod_reg;
    logic [15:0]                cnt_reg;
    logic [15:0]                cnt_next;
    logic [15:0]                cnt_step;
    logic [7:0]                 hi_latch_reg;
    logic [7:0]                 rd_data_reg;
    logic [7:0]                 rd_next;
    logic                       down_reg;
    logic                       down_next;
    logic [15:0]                chv_reg   [CHANNELS];
    logic [15:0]                eff_reg   [CHANNELS];
    logic [15:0]                eff_next  [CHANNELS];
    logic [CHANNELS-1:0]        pwm_reg;
    logic [CHANNELS-1:0]        pwm_next;
    logic [CHANNELS-1:0]        pend_reg;
    logic [CHANNELS-1:0]        pend_next;
    logic [CHANNELS-1:0]        catch_reg;
    logic [CHANNELS-1:0]        catch_next;
    logic [CHANNELS-1:0]        chv_lo_wr;
    logic [15:0]                wr_word;
    logic                       center;
    logic                       run;
    logic                       tick;
    logic                       step;
    logic                       period_start;
    logic                       wr_ctrl;
    logic                       wr_cnt;
    logic                       wr_mod_lo;
    logic                       wr_hi_any;

    function automatic logic [3:0] chv_addr(input int ch, input logic lo);
        chv_addr = 4'(tpb_pkg::ADDR_CHV_BASE + 4'(2 * ch) + {3'b000, lo});
    endfunction

    // ****************************************
    // Address decode
    // ****************************************
    assign wr_ctrl   = wr_en && (addr == tpb_pkg::ADDR_CTRL);
    assign wr_cnt    = wr_en && (addr == tpb_pkg::ADDR_CNT_HI || addr == tpb_pkg::ADDR_CNT_LO);
    assign wr_mod_lo = wr_en && (addr == tpb_pkg::ADDR_MOD_LO);
    // High byte parks in a latch, low byte commits the word
    assign wr_word   = {hi_latch_reg, wr_data};

    always_comb begin
        wr_hi_any = wr_en && (addr == tpb_pkg::ADDR_MOD_HI);
        for (int i = 0; i < CHANNELS; i++) begin
            chv_lo_wr[i] = wr_en && (addr == chv_addr(i, 1'b1));
            if (wr_en && addr == chv_addr(i, 1'b0)) begin
                wr_hi_any = 1'b1;
            end
        end
    end

    // ****************************************
    // Prescaler and counter
    // ****************************************
    assign center = ctrl_reg[tpb_pkg::CENTER_BIT];
    assign run    = ctrl_reg[tpb_pkg::SRC_LSB +: tpb_pkg::SRC_W] != tpb_pkg::SRC_OFF;

    tpb_prescaler #(
        .DIV_W    (tpb_pkg::PRESCALE_DIV_W)
    ) u_prescaler (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (run),
        .sel      (ctrl_reg[tpb_pkg::PS_LSB +: tpb_pkg::PS_W]),
        .tick     (tick)
    );

    // Clearing write beats a prescaled tick in the same cycle
    assign step = tick && !wr_cnt;

    // Center mode runs up then down
    assign cnt_step = center ? (down_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001)
                             : ((cnt_reg == mod_reg) ? 16'h0000 : cnt_reg + 16'h0001);

    assign period_start = center ? (step && !down_reg && cnt_step == mod_reg)
                                 : (step && cnt_reg == mod_reg);

    assign cnt_next = wr_cnt ? tpb_pkg::CNT_RESET : (step ? cnt_step : cnt_reg);

    // Direction flips as modulo is reached
    assign down_next = (center && step && !down_reg && cnt_step == mod_reg) ? 1'b1 :
                       (center && step && down_reg && cnt_step == 16'h0000) ? 1'b0 :
                       down_reg;

    // ****************************************
    // Channel outputs
    // ****************************************
    always_comb begin
        logic [15:0] v;
        logic        neg;
        logic        set_ev;
        logic        catch_ev;
        logic        clr_ev;
        v        = '0;
        neg      = 1'b0;
        set_ev   = 1'b0;
        catch_ev = 1'b0;
        clr_ev   = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            v             = chv_reg[i];
            neg           = v[15];
            pwm_next[i]   = pwm_reg[i];
            eff_next[i]   = eff_reg[i];
            catch_next[i] = catch_reg[i];
            pend_next[i]  = pend_reg[i];
            if (center) begin
                eff_next[i] = v;
                // Modulo value is only ever met counting up
                set_ev   = step && down_reg && cnt_step == v && v != 16'h0000
                           && v != mod_reg - 16'h0001;
                // Late zero to non-zero catches up at count zero
                catch_ev = step && down_reg && cnt_step == 16'h0000 && pend_reg[i]
                           && v != 16'h0000;
                // Catch-up pulse ignores up-count match until period end
                // Zero channel never matches, cleared at period start
                clr_ev   = (step && !down_reg && cnt_step == v && !catch_reg[i])
                           || (period_start && v == 16'h0000);
                if (neg) begin
                    pwm_next[i] = 1'b0;
                end else if (set_ev || catch_ev) begin
                    pwm_next[i] = 1'b1;
                end else if (clr_ev) begin
                    pwm_next[i] = 1'b0;
                end
                if (period_start) begin
                    catch_next[i] = 1'b0;
                    pend_next[i]  = 1'b0;
                end else if (catch_ev) begin
                    catch_next[i] = 1'b1;
                    pend_next[i]  = 1'b0;
                end
                if (chv_lo_wr[i] && v == 16'h0000 && wr_word != 16'h0000 && down_reg) begin
                    pend_next[i] = 1'b1;
                end
            end else begin
                catch_next[i] = 1'b0;
                pend_next[i]  = 1'b0;
                if (period_start) begin
                    // Start decision uses the value latched a period ago
                    pwm_next[i] = eff_reg[i] != 16'h0000 && !eff_reg[i][15];
                    eff_next[i] = v;
                end else if (step && cnt_step == eff_reg[i]) begin
                    pwm_next[i] = 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rd_next = tpb_pkg::RD_IDLE;
        if (addr == tpb_pkg::ADDR_CTRL) begin
            rd_next = {1'b0, down_reg, ctrl_reg};
        end else if (addr == tpb_pkg::ADDR_CNT_HI) begin
            rd_next = cnt_reg[15:8];
        end else if (addr == tpb_pkg::ADDR_CNT_LO) begin
            rd_next = cnt_reg[7:0];
        end else if (addr == tpb_pkg::ADDR_MOD_HI) begin
            rd_next = mod_reg[15:8];
        end else if (addr == tpb_pkg::ADDR_MOD_LO) begin
            rd_next = mod_reg[7:0];
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (addr == chv_addr(i, 1'b0)) begin
                    rd_next = chv_reg[i][15:8];
                end else if (addr == chv_addr(i, 1'b1)) begin
                    rd_next = chv_reg[i][7:0];
                end
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg     <= tpb_pkg::CTRL_RESET;
            mod_reg      <= tpb_pkg::MOD_RESET;
            hi_latch_reg <= tpb_pkg::LATCH_RESET;
            rd_data_reg  <= tpb_pkg::RD_IDLE;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wr_data[tpb_pkg::CTRL_W-1:0];
            end
            if (wr_hi_any) begin
                hi_latch_reg <= wr_data;
            end
            if (wr_mod_lo) begin
                mod_reg <= wr_word;
            end
            rd_data_reg <= rd_en ? rd_next : tpb_pkg::RD_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= tpb_pkg::CNT_RESET;
            down_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            down_reg <= down_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_reg   <= '0;
            pend_reg  <= '0;
            catch_reg <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                chv_reg[i] <= tpb_pkg::CHV_RESET;
                eff_reg[i] <= tpb_pkg::CHV_RESET;
            end
        end else begin
            pwm_reg   <= pwm_next;
            pend_reg  <= pend_next;
            catch_reg <= catch_next;
            for (int i = 0; i < CHANNELS; i++) begin
                eff_reg[i] <= eff_next[i];
                if (chv_lo_wr[i]) begin
                    chv_reg[i] <= wr_word;
                end
            end
        end
    end

    assign rd_data = rd_data_reg;
    assign pwm_out = pwm_reg;

    // ****************************************
    // Checks, channel 0 stands for all
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_up_into_mod;
        step && center && !down_reg && cnt_step == mod_reg && !wr_en;
    endsequence

    sequence s_down_to_zero;
        step && center && down_reg && cnt_reg == 16'h0001;
    endsequence

    sequence s_catch_up;
        step && center && down_reg && cnt_step == 16'h0000 && pend_reg[0]
            && !chv_reg[0][15] && chv_reg[0] != 16'h0000;
    endsequence

    a_bounce_at_zero: assert property (
        s_down_to_zero |=> !down_reg && cnt_reg == 16'h0000
    ) else $error("Counter did not turn at zero");

    a_turn_at_mod: assert property (
        s_up_into_mod |=> down_reg && cnt_reg == mod_reg
    ) else $error("Counter did not turn after modulo");

    a_eq_mod_idle: assert property (
        center && chv_reg[0] == mod_reg && !pwm_reg[0] && !pend_reg[0]
            && cnt_reg <= mod_reg |=> !pwm_reg[0]
    ) else $error("Channel at modulo went active");

    a_mod_less_idle: assert property (
        center && chv_reg[0] == mod_reg - 16'h0001 && !pwm_reg[0] && !pend_reg[0]
            |=> !pwm_reg[0]
    ) else $error("Channel at modulo minus one went active");

    a_negative_idle: assert property (
        center && chv_reg[0][15] |=> !pwm_reg[0]
    ) else $error("Negative channel value drove output");

    a_zero_catch_up: assert property (
        s_catch_up |=> pwm_reg[0] && catch_reg[0]
    ) else $error("No catch-up pulse at count zero");

    a_zero_holds_active: assert property (
        center && pwm_reg[0] && chv_reg[0] == 16'h0000
            && !(step && !down_reg && (cnt_step == mod_reg || cnt_step == 16'h0000))
            |=> pwm_reg[0]
    ) else $error("Zero channel ended pulse before period end");

    a_catch_holds: assert property (
        center && catch_reg[0] && pwm_reg[0] && !period_start && !chv_reg[0][15]
            |=> pwm_reg[0]
    ) else $error("Catch-up pulse ended early");

    a_edge_extra_zero: assert property (
        !center && period_start && eff_reg[0] == 16'h0000 |=> !pwm_reg[0]
    ) else $error("Edge mode skipped the extra idle period");

    a_stop_holds: assert property (
        !run && !wr_cnt |=> $stable(cnt_reg)
    ) else $error("Counter moved while stopped");

    a_clear_count: assert property (
        wr_cnt |=> cnt_reg == 16'h0000 && $stable(down_reg)
    ) else $error("Counter write did not clear");

    a_clear_keeps_dir: assert property (
        center && step && down_reg && cnt_reg == 16'h0000 |=> cnt_reg == 16'hFFFF
    ) else $error("Cleared counter did not wrap downward");

    a_edge_match_off: assert property (
        !center && step && cnt_reg != mod_reg && cnt_step == eff_reg[0] |=> !pwm_reg[0]
    ) else $error("Edge output not cleared on match");

endmodule

// ---- tpb_timer_pwm_bench.sv ----
module tpb_timer_pwm_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and instance
    // ****************************************
    localparam int CH        = 2;
    // Tests should need well under 10000 cycles
    localparam int MAX_CYCLE = 30000;

    logic          core_clk;
    logic          resetn;
    logic [3:0]    addr;
    logic [7:0]    wr_data;
    logic          wr_en;
    logic          rd_en;
    logic [7:0]    rd_data;
    logic [CH-1:0] pwm_out;
    int            n_mismatch;
    int            n_compared;
    int            cycles;
    int            k;
    logic [7:0]    v;
    logic [7:0]    w;
    logic [15:0]   tv [5] = '{16'h0003, 16'h0008, 16'h0007, 16'h8000, 16'hFFFF};
    int            te [5] = '{24, 0, 0, 0, 0};

    tpb_timer_pwm #(.CHANNELS(CH)) i_tpb_timer_pwm (
        .core_clk (core_clk),
        .resetn   (resetn),
        .addr     (addr),
        .wr_data  (wr_data),
        .wr_en    (wr_en),
        .rd_en    (rd_en),
        .rd_data  (rd_data),
        .pwm_out  (pwm_out)
    );

    always #10 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == MAX_CYCLE) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task print_verdict;
        $display("Counts: %0d compared, %0d mismatches", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr_en   <= 1'h1;
        addr    <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en   <= 1'h0;
    endtask

    // Data is taken in the single cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        rd_en <= 1'h1;
        addr  <= a;
        @(posedge core_clk);
        rd_en <= 1'h0;
        #1 d = rd_data;
    endtask

    // High byte first, low byte commits both
    task wr16(input logic [3:0] a, input logic [15:0] val);
        wr(a, val[15:8]);
        wr(a + 4'h1, val[7:0]);
    endtask

    // Sampled on the falling edge, away from register updates
    task highs(input int c, input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(negedge core_clk);
            if (pwm_out[c] === 1'h1)
                cnt++;
        end
    endtask

    task wait_dir(input logic d);
        for (int i = 0; i < 500; i++) begin
            rd(tpb_pkg::ADDR_CTRL, v);
            if (v[6] === d)
                break;
        end
    endtask

    function automatic logic [7:0] ctl(input logic [2:0] ps, input logic run, input logic ctr);
        return {2'h0, ctr, 1'h0, run, ps};
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        core_clk = 1'h0;
        resetn   = 1'h0;
        addr     = 4'h0;
        wr_data  = 8'h00;
        wr_en    = 1'h0;
        rd_en    = 1'h0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'h1;
        repeat (5) @(posedge core_clk);
        check({14'h0000, pwm_out}, 16'h0000);

        rd(tpb_pkg::ADDR_CTRL, v);   check({8'h00, v}, {8'h00, 2'h0, tpb_pkg::CTRL_RESET});
        @(posedge core_clk);
        #1 check({8'h00, rd_data}, {8'h00, tpb_pkg::RD_IDLE});
        rd(tpb_pkg::ADDR_MOD_HI, v); check({8'h00, v}, {8'h00, tpb_pkg::MOD_RESET[15:8]});
        rd(tpb_pkg::ADDR_MOD_LO, v); check({8'h00, v}, {8'h00, tpb_pkg::MOD_RESET[7:0]});
        rd(4'h6, v);                 check({8'h00, v}, {8'h00, tpb_pkg::CHV_RESET[7:0]});
        rd(tpb_pkg::ADDR_CNT_LO, v); check({8'h00, v}, 16'h0000);
        rd(4'hF, v);                 check({8'h00, v}, {8'h00, tpb_pkg::RD_IDLE});
        $display("test reset_values done");

        wr16(tpb_pkg::ADDR_MOD_HI, 16'h0008);
        wr16(4'h7, 16'h0003);
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h0, 1'h1, 1'h1));
        for (int i = 0; i < 5; i++) begin
            wr16(4'h5, tv[i]);
            repeat (48) @(posedge core_clk);
            highs(0, 64, k);
            check(16'(k), 16'(te[i]));
            if (i == 0) begin
                highs(0, 16, k);
                check(16'(k), 16'h0006);
                highs(1, 16, k);
                check(16'(k), 16'h0006);
            end
        end
        // Same prescale and modulo, channel value 6: even, never modulo minus one
        wr16(4'h5, 16'h0006);
        repeat (48) @(posedge core_clk);
        highs(0, 32, k);
        check(16'(k), 16'h0018);
        $display("test center_duty done");

        // Slow the count so the bus can follow the direction
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h3, 1'h1, 1'h1));
        wr16(4'h5, 16'h0003);
        repeat (256) @(posedge core_clk);
        wait_dir(1'h1);
        wait_dir(1'h0);
        wr16(4'h5, 16'h0000);
        highs(0, 48, k); check(16'(k), 16'h0030);
        repeat (40) @(posedge core_clk);
        highs(0, 32, k); check(16'(k), 16'h0000);
        wait_dir(1'h0);
        wait_dir(1'h1);
        wr16(4'h5, 16'h0003);
        highs(0, 80, k); check(16'(k > 0), 16'h0001);
        wait_dir(1'h1);
        wr16(4'h5, 16'h0000);
        highs(0, 96, k); check(16'(k), 16'h0060);
        repeat (40) @(posedge core_clk);
        highs(0, 64, k); check(16'(k), 16'h0000);
        $display("test center_zero_change done");

        // Stop just after the bottom so the direction is up
        wait_dir(1'h0);
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h0, 1'h0, 1'h0));
        wr16(tpb_pkg::ADDR_MOD_HI, 16'h000F);
        wr(tpb_pkg::ADDR_CNT_LO, 8'h00);
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h0, 1'h1, 1'h0));
        highs(0, 48, k); check(16'(k), 16'h0000);
        wr16(4'h5, 16'h0002);
        highs(0, 16, k); check(16'(k), 16'h0000);
        repeat (16) @(posedge core_clk);
        highs(0, 64, k); check(16'(k), 16'h0008);
        $display("test edge_duty done");

        wr16(tpb_pkg::ADDR_MOD_HI, 16'h0320);
        rd(tpb_pkg::ADDR_MOD_HI, v); check({8'h00, v}, 16'h0003);
        rd(tpb_pkg::ADDR_MOD_LO, v); check({8'h00, v}, 16'h0020);
        for (int ps = 1; ps < 8; ps++) begin
            wr(tpb_pkg::ADDR_CTRL, ctl(3'(ps), 1'h1, 1'h0));
            wr(tpb_pkg::ADDR_CNT_LO, 8'h00);
            rd(tpb_pkg::ADDR_CNT_LO, v);
            repeat (254) @(posedge core_clk);
            rd(tpb_pkg::ADDR_CNT_LO, w);
            check({8'h00, w - v}, 16'(256 >> ps));
        end
        $display("test prescale done");

        // Divider left half way, then stopped, cleared and restarted
        rd(tpb_pkg::ADDR_CNT_LO, w);
        for (int i = 0; i < 200; i++) begin
            rd(tpb_pkg::ADDR_CNT_LO, v);
            if (v !== w)
                break;
        end
        repeat (60) @(posedge core_clk);
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h7, 1'h0, 1'h0));
        rd(tpb_pkg::ADDR_CNT_LO, v);
        repeat (300) @(posedge core_clk);
        rd(tpb_pkg::ADDR_CNT_LO, w); check({8'h00, w}, {8'h00, v});
        wr(tpb_pkg::ADDR_CNT_HI, 8'h5A);
        rd(tpb_pkg::ADDR_CNT_LO, v); check({8'h00, v}, 16'h0000);
        rd(tpb_pkg::ADDR_CNT_HI, v); check({8'h00, v}, 16'h0000);
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h7, 1'h1, 1'h0));
        k = 0;
        for (int i = 0; i < 100; i++) begin
            rd(tpb_pkg::ADDR_CNT_LO, v);
            k = k + 2;
            if (v !== 8'h00)
                break;
        end
        check(16'(k > 40 && k < 100), 16'h0001);
        $display("test stop_restart done");

        wr(tpb_pkg::ADDR_CTRL, ctl(3'h7, 1'h0, 1'h1));
        wr16(tpb_pkg::ADDR_MOD_HI, 16'h0008);
        wr(tpb_pkg::ADDR_CNT_LO, 8'h00);
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h7, 1'h1, 1'h1));
        for (int i = 0; i < 700; i++) begin
            rd(tpb_pkg::ADDR_CNT_LO, v);
            if (v === 8'h08)
                break;
        end
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h7, 1'h0, 1'h1));
        rd(tpb_pkg::ADDR_CTRL, v); check({15'h0000, v[6]}, 16'h0001);
        wr(tpb_pkg::ADDR_CNT_LO, 8'h33);
        rd(tpb_pkg::ADDR_CTRL, v); check({15'h0000, v[6]}, 16'h0001);
        rd(tpb_pkg::ADDR_CNT_HI, v); check({8'h00, v}, 16'h0000);
        wr(tpb_pkg::ADDR_CTRL, ctl(3'h0, 1'h1, 1'h1));
        repeat (20) @(posedge core_clk);
        rd(tpb_pkg::ADDR_CNT_HI, v); check({8'h00, v}, 16'h00FF);
        $display("test direction_kept done");

        print_verdict();
    end
endmodule
